// >>> hdl/gat_cmd_frontend.sv
// APB command front end for trial address translations.
// Assumes an outside walker that answers each request with one done pulse
// on mclk, result word alongside.
//
// Notes on behaviour
// [RULE_01] Any command write starts a translation; outcome lands in result reg. Here a command write while busy is dropped.
// [RULE_02] Command registers are 32-bit and write-only.
// [RULE_03] Page address from bits 31:12; bits 11:8 reserved.
// [RULE_04] Bits 7:0 select the context bank for stage 1.
// [RULE_05] Privileged-read commands (both kinds) check as a privileged read.
// [RULE_06] Stage 1 privileged write checks as a privileged write.
// [RULE_07] Stage 1 unprivileged read checks as an unprivileged read.
// [RULE_08] Stage 1 unprivileged write checks as an unprivileged write.
// [RULE_09] Stage 1 commands do only the first stage, no second stage.
// [RULE_10] Combined command does stage 1 then stage 2.
// [RULE_11] Access security state picks secure or non-secure command bank.
// [RULE_12] Secure copies exist only with security support present.
// [RULE_13] Secure-only alias reaches the non-secure command copies.
// [RULE_14] Status active bit is 1 while a command is in progress.
// [RULE_15] Software must not issue a command while one is active.
// [RULE_16] Reserved bits ignored; command reads return zero, no side effect.
// [RULE_17] Active clears in the cycle the result register is written.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module gat_cmd_frontend
	import gat_pkg::*;
#(
	parameter bit SEC_EXT = 1'b1
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	input  wire logic [3:0]        pstrb,
	input  wire logic [2:0]        pprot,
	output logic                   pready,
	output logic [DATA_W-1:0]      prdata,
	output logic                   pslverr,
	output logic                   xlatReq,
	output logic [PAGE_W-1:0]      xlatPage,
	output logic [CTX_W-1:0]       xlatCtx,
	output logic                   xlatPriv,
	output logic                   xlatWrite,
	output logic                   xlatTwoStage,
	output logic                   xlatSecure,
	input  wire logic              xlatDone,
	input  wire logic [DATA_W-1:0] xlatResult
);

	// ---------------------------------------------------------------
	// Reset release
	// ---------------------------------------------------------------
	logic rstMeta_q;
	logic rstSync_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end

	// Assert at once, release two edges later so no flop leaves reset alone
	wire logic srst_n = rstSync_q;

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	logic              accSecure;
	logic              inAlias;
	logic              bankSel;
	logic [ADDR_W-1:0] winOfs;
	logic              isCmd;
	logic              isResult;
	logic              isStatus;
	logic              decErr;

	always_comb begin
		// Without security support every access is seen as non-secure
		accSecure = SEC_EXT && !pprot[PROT_NS_BIT];           // [RULE_12]
		inAlias   = (paddr & ~WIN_MASK) == ALIAS_BASE;
		winOfs    = paddr & WIN_MASK;
		bankSel   = inAlias ? 1'b0 : accSecure;                // [RULE_11] [RULE_13]
		isCmd     = (winOfs == OFS_S1_PRIV_READ)
		         || (winOfs == OFS_S1_PRIV_WRITE)
		         || (winOfs == OFS_S1_USER_READ)
		         || (winOfs == OFS_S1_USER_WRITE)
		         || (winOfs == OFS_S12_PRIV_READ);
		isResult  = winOfs == OFS_RESULT;
		isStatus  = winOfs == OFS_STATUS;
		// Alias is secure-only; anything outside both windows is unmapped
		decErr    = !(isCmd || isResult || isStatus)
		         || (inAlias && !accSecure)                    // [RULE_13]
		         || (!inAlias && (paddr & ~WIN_MASK) != ZERO_WORD[ADDR_W-1:0]);
	end

	// ---------------------------------------------------------------
	// APB handshake: one wait state, answer registered
	// ---------------------------------------------------------------
	logic              pready_q;
	logic              pready_d;
	logic [DATA_W-1:0] prdata_q;
	logic [DATA_W-1:0] prdata_d;
	logic              pslverr_q;
	logic              pslverr_d;
	logic [DATA_W-1:0] result_q [NBANK];
	logic              state_bank_active [NBANK];

	wire logic accDone = psel && penable && pready_q;

	always_comb begin
		pready_d  = psel && penable && !pready_q;
		prdata_d  = ZERO_WORD;
		pslverr_d = 1'b0;
		if (pready_d) begin
			pslverr_d = decErr || (!pwrite && 1'b0);
			if (!pwrite && !decErr) begin
				// Command registers read as zero with no side effect
				if (isResult) begin                            // [RULE_16] [RULE_02]
					prdata_d = result_q[bankSel];
				end else if (isStatus) begin
					prdata_d = ZERO_WORD;
					prdata_d[STAT_ACTIVE_BIT] = state_bank_active[bankSel]; // [RULE_14]
				end
			end
			// Result and status are read-only; writes there are refused
			if (pwrite && (isResult || isStatus)) begin
				pslverr_d = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge srst_n) begin
		if (!srst_n) begin
			pready_q  <= 1'b0;
			prdata_q  <= ZERO_WORD;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= pready_d;
			prdata_q  <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign pready  = pready_q;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	// ---------------------------------------------------------------
	// Command sequencing
	// ---------------------------------------------------------------
	gat_state_t        state_q;
	gat_state_t        state_d;
	logic              reqBank_q;
	logic              reqBank_d;
	logic              xlatReq_q;
	logic              xlatReq_d;
	logic [PAGE_W-1:0] page_q;
	logic [PAGE_W-1:0] page_d;
	logic [CTX_W-1:0]  ctx_q;
	logic [CTX_W-1:0]  ctx_d;
	logic              priv_q;
	logic              priv_d;
	logic              wr_q;
	logic              wr_d;
	logic              two_q;
	logic              two_d;
	logic              cmdWrite;
	logic              finish;

	// Partial-strobe writes still start the command; the word is taken whole
	assign cmdWrite = accDone && pwrite && isCmd && !decErr;    // [RULE_02]
	assign finish   = (state_q == GAT_BUSY) && xlatDone;

	// One walk in flight for both banks: a command from either security
	// state while busy is dropped without an error response

	always_comb begin
		state_d   = state_q;
		reqBank_d = reqBank_q;
		xlatReq_d = 1'b0;
		page_d    = page_q;
		ctx_d     = ctx_q;
		priv_d    = priv_q;
		wr_d      = wr_q;
		two_d     = two_q;
		unique case (state_q)
			GAT_IDLE: begin
				// A second command while busy is dropped, not queued
				if (cmdWrite) begin                            // [RULE_01] [RULE_15]
					state_d   = GAT_BUSY;
					xlatReq_d = 1'b1;
					reqBank_d = bankSel;                       // [RULE_11]
					page_d    = pwdata[PAGE_HI:PAGE_LO];       // [RULE_03] [RULE_16]
					ctx_d     = pwdata[CTX_HI:CTX_LO];         // [RULE_04]
					unique case (winOfs)
						OFS_S1_PRIV_WRITE: begin               // [RULE_06]
							priv_d = 1'b1;
							wr_d   = 1'b1;
							two_d  = 1'b0;
						end
						OFS_S1_USER_READ: begin                // [RULE_07]
							priv_d = 1'b0;
							wr_d   = 1'b0;
							two_d  = 1'b0;
						end
						OFS_S1_USER_WRITE: begin               // [RULE_08]
							priv_d = 1'b0;
							wr_d   = 1'b1;
							two_d  = 1'b0;
						end
						OFS_S12_PRIV_READ: begin               // [RULE_05] [RULE_10]
							priv_d = 1'b1;
							wr_d   = 1'b0;
							two_d  = 1'b1;
						end
						default: begin                         // [RULE_05] [RULE_09]
							priv_d = 1'b1;
							wr_d   = 1'b0;
							two_d  = 1'b0;
						end
					endcase
				end
			end
			GAT_BUSY: begin
				if (xlatDone) begin                            // [RULE_17]
					state_d = GAT_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge srst_n) begin
		if (!srst_n) begin
			state_q   <= GAT_IDLE;
			reqBank_q <= 1'b0;
			xlatReq_q <= 1'b0;
			page_q    <= '0;
			ctx_q     <= '0;
			priv_q    <= 1'b0;
			wr_q      <= 1'b0;
			two_q     <= 1'b0;
		end else begin
			state_q   <= state_d;
			reqBank_q <= reqBank_d;
			xlatReq_q <= xlatReq_d;
			page_q    <= page_d;
			ctx_q     <= ctx_d;
			priv_q    <= priv_d;
			wr_q      <= wr_d;
			two_q     <= two_d;
		end
	end

	assign xlatReq      = xlatReq_q;
	assign xlatPage     = page_q;
	assign xlatCtx      = ctx_q;
	assign xlatPriv     = priv_q;
	assign xlatWrite    = wr_q;
	assign xlatTwoStage = two_q;                                // [RULE_09] [RULE_10]
	assign xlatSecure   = reqBank_q;

	// ---------------------------------------------------------------
	// Per-bank result registers and active view
	// ---------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < NBANK; b++) begin : gBank
			// Bank number as one bit, to compare with the stored bank
			localparam bit BANK_ID = 1'(b);

			logic [DATA_W-1:0] res_d;

			always_comb begin
				res_d = result_q[b];
				// Result write and active fall happen on the same edge
				if (finish && reqBank_q == BANK_ID) begin      // [RULE_01] [RULE_17]
					res_d = xlatResult;
				end
				state_bank_active[b] = (state_q == GAT_BUSY)
				                    && (reqBank_q == BANK_ID); // [RULE_14]
			end

			always_ff @(posedge mclk or negedge srst_n) begin
				if (!srst_n) begin
					result_q[b] <= RESULT_RST;
				end else begin
					result_q[b] <= res_d;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// >>> hdl/gat_pkg.sv
// Package for the global address translation command front end.
// Assumes a 100 MHz mclk and an APB master with 32-bit data.
`default_nettype none

package gat_pkg;

	// -----------------------------------------------------------------
	// Bus and field widths
	// -----------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;
	localparam int PAGE_W = 20;
	localparam int CTX_W  = 8;

	// Command word fields
	localparam int PAGE_HI = 31;
	localparam int PAGE_LO = 12;
	localparam int RSV_HI  = 11;
	localparam int RSV_LO  = 8;
	localparam int CTX_HI  = 7;
	localparam int CTX_LO  = 0;

	// Status word field
	localparam int STAT_ACTIVE_BIT = 0;

	// pprot bit that marks a non-secure access
	localparam int PROT_NS_BIT = 1;

	// -----------------------------------------------------------------
	// Register byte offsets within one bank window
	// -----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_S1_PRIV_READ  = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_S1_PRIV_WRITE = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_S1_USER_READ  = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_S1_USER_WRITE = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_S12_PRIV_READ = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_RESULT        = 12'h020;
	localparam logic [ADDR_W-1:0] OFS_STATUS        = 12'h024;

	// Secure-only alias window onto the non-secure copies
	localparam logic [ADDR_W-1:0] ALIAS_BASE = 12'h040;
	localparam logic [ADDR_W-1:0] WIN_MASK   = 12'h03f;

	localparam logic [DATA_W-1:0] ZERO_WORD   = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RESULT_RST  = 32'h0000_0000;

	// Bank indices
	localparam int BANK_NS = 0;
	localparam int BANK_S  = 1;
	localparam int NBANK   = 2;

	// -----------------------------------------------------------------
	// Types
	// -----------------------------------------------------------------
	typedef enum logic [0:0] {
		GAT_IDLE = 1'b0,
		GAT_BUSY = 1'b1
	} gat_state_t;

endpackage

`default_nettype wire

// >>> test/gat_assertions.sv
// Port checks for the translation command front end.
// Assumes binding onto gat_cmd_frontend with SEC_EXT set.
`timescale 1ns/1ps
`default_nettype none
module gat_assertions
	import gat_pkg::*;
(
	input wire logic              mclk,
	input wire logic              rst_n,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [2:0]        pprot,
	input wire logic              pready,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic              xlatReq,
	input wire logic [PAGE_W-1:0] xlatPage,
	input wire logic [CTX_W-1:0]  xlatCtx,
	input wire logic              xlatPriv,
	input wire logic              xlatWrite,
	input wire logic              xlatTwoStage,
	input wire logic              xlatSecure
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_req; xlatReq |-> $past(psel && penable && pwrite); endproperty
	a_req: assert property (p_req) else $error("stray request");
	property p_pulse; xlatReq |=> !xlatReq; endproperty
	a_pulse: assert property (p_pulse) else $error("long request");
	property p_page; xlatReq |-> xlatPage == $past(pwdata[31:12]); endproperty
	a_page: assert property (p_page) else $error("bad page");
	property p_ctx; xlatReq |-> xlatCtx == $past(pwdata[7:0]); endproperty
	a_ctx: assert property (p_ctx) else $error("bad index");
	property p_priv; xlatReq |-> xlatPriv == !$past(paddr[3]); endproperty
	a_priv: assert property (p_priv) else $error("bad priv");
	property p_wr; xlatReq |-> xlatWrite == $past(paddr[2]); endproperty
	a_wr: assert property (p_wr) else $error("bad dir");
	property p_two; xlatReq |-> xlatTwoStage == $past(paddr[4]); endproperty
	a_two: assert property (p_two) else $error("bad stage");
	property p_sec;
		xlatReq |-> xlatSecure == !$past(pprot[1] || paddr[6]);
	endproperty
	a_sec: assert property (p_sec) else $error("bad bank");
	property p_rdy; psel && !penable |=> !pready ##1 pready; endproperty
	a_rdy: assert property (p_rdy) else $error("bad wait");
	property p_rz;
		pready && !pwrite && paddr[5:0] < 6'h14 |-> prdata == '0;
	endproperty
	a_rz: assert property (p_rz) else $error("cmd read");
endmodule
`default_nettype wire

// >>> test/tb_global_addr_translate_cmd.sv
// Self-checking bench for the translation command front end.
// Assumes the bench acts as APB master and as the walker.
`timescale 1ns/1ps
`default_nettype none
module tb_global_addr_translate_cmd
	import gat_pkg::*;
;
	logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic xlatDone = 0, er;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, xlatResult = '0, rd, prdata;
	logic [2:0] pprot = '0;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, xlatReq, xlatPriv, xlatWrite;
	logic xlatTwoStage, xlatSecure;
	logic [PAGE_W-1:0] xlatPage;
	logic [CTX_W-1:0] xlatCtx;
	int num_errors = 0;
	int num_checks = 0;
	gat_cmd_frontend dut (.*);
	// ----
	// Helpers
	// ----
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Waits on pready, never on a fixed count; one idle edge before setup
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [2:0] pr);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pprot <= pr;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic done(input logic [31:0] r);
		@(posedge mclk);
		xlatDone <= 1'b1;
		xlatResult <= r;
		@(posedge mclk);
		xlatDone <= 1'b0;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_cmds;
		logic [31:0] d;
		for (int i = 0; i < 5; i++) begin
			d = {20'h5a5a0 + 20'(i), 4'hf, 8'hc0 + 8'(i)};
			apb(1'b1, 12'(4 * i), d, 3'h0);
			#1;
			chk("req", xlatReq, 1);
			chk("page", xlatPage, d[31:12]);
			chk("ctx", xlatCtx, d[7:0]);
			chk("priv", xlatPriv, i != 2 && i != 3);
			chk("wr", xlatWrite, i == 1 || i == 3);
			chk("two", xlatTwoStage, i == 4);
			chk("sec", xlatSecure, 1);
			apb(1'b0, OFS_STATUS, '0, 3'h0);
			chk("act", rd, 1);
			done(32'h1234_0000 + i);
			apb(1'b0, OFS_RESULT, '0, 3'h0);
			chk("res", rd, 32'h1234_0000 + i);
			apb(1'b0, OFS_STATUS, '0, 3'h0);
			chk("idle", rd, 0);
			apb(1'b0, 12'(4 * i), '0, 3'h0);
			chk("cmdrd", rd, 0);
			chk("cmderr", er, 0);
		end
		$display("test commands done");
	endtask
	task automatic t_banks;
		apb(1'b1, OFS_S1_PRIV_READ, 32'h0000_1001, 3'h2);
		#1;
		chk("nsec", xlatSecure, 0);
		done(32'h0bad_0001);
		apb(1'b0, OFS_RESULT, '0, 3'h2);
		chk("nsres", rd, 32'h0bad_0001);
		apb(1'b0, OFS_RESULT, '0, 3'h0);
		chk("sres", rd, 32'h1234_0004);
		apb(1'b1, ALIAS_BASE + OFS_S1_USER_WRITE, 32'h2002, 3'h0);
		#1;
		chk("alias", {xlatReq, xlatSecure}, 2);
		apb(1'b1, ALIAS_BASE + OFS_S1_PRIV_READ, 32'h3003, 3'h0);
		#1;
		chk("drop", xlatReq, 0);
		chk("dctx", xlatCtx, 8'h02);
		done(32'h0bad_0002);
		apb(1'b0, ALIAS_BASE + OFS_RESULT, '0, 3'h0);
		chk("ares", rd, 32'h0bad_0002);
		apb(1'b0, ALIAS_BASE, '0, 3'h2);
		chk("nsalias", er, 1);
		apb(1'b0, 12'h030, '0, 3'h0);
		chk("unmap", er, 1);
		apb(1'b1, OFS_RESULT, '0, 3'h0);
		chk("rowr", er, 1);
		$display("test banks done");
	endtask
	// ----
	// Run
	// ----
	initial begin
		forever #5 mclk = ~mclk;
	end
	initial begin
		#100us;
		num_errors++;
		test_done;
	end
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		t_cmds;
		t_banks;
		test_done;
	end
endmodule
bind gat_cmd_frontend gat_assertions u_chk (
	.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot),
	.pready(pready), .prdata(prdata), .xlatReq(xlatReq),
	.xlatPage(xlatPage), .xlatCtx(xlatCtx), .xlatPriv(xlatPriv),
	.xlatWrite(xlatWrite), .xlatTwoStage(xlatTwoStage),
	.xlatSecure(xlatSecure)
);
`default_nettype wire
